// >>> src/sample_post_pkg.sv
// constants shared by both ends of the sample link
// Notes on behaviour
// - formats 1 and 2 append common-mode byte
// - common-mode byte steps ref/256, clamps 0..255
// - offset and gain never touch common-mode byte
// - average sums 2^N samples, clears each block
// - averaging only in format 3, N 1..16
// - averaged word 32 bits, lower 30 average
// - constant input: top 24 average bits equal it
// - word bit 30 flags saturation within block
// - word bit 31 marks fresh block average
// - exponent resets to zero; rate strobe/2^N
// - per-channel signed 24-bit offset, default zero
// - per-channel gain factor/0x8000, default 0x8000
// - clamp result to 0x7fffff .. 0x800000
// - test word on both channels, normal timing
// - format 4 selects test word 0x5a5a0f0f
// - one format for both channels
// - soft reset needs both bits, one write
// - host holds hardware reset low 50 ns
// - any reset sets flag; write one clears
// - power-on reset restores all configuration
// - host waits 750 us after reset
// - host waits 3 ms, then resets
`default_nettype none
package sample_post_pkg;
  // ***************************************************************
  // output formats
  // ***************************************************************
  localparam logic [2:0] FMT_DIFF24 = 3'h0;
  localparam logic [2:0] FMT_CM16 = 3'h1;
  localparam logic [2:0] FMT_CM24 = 3'h2;
  localparam logic [2:0] FMT_AVG = 3'h3;
  localparam logic [2:0] FMT_TEST = 3'h4;
  // ***************************************************************
  // device register indices and fields
  // ***************************************************************
  localparam logic [3:0] REG_FORMAT = 4'h0;
  localparam logic [3:0] REG_AVG = 4'h1;
  localparam logic [3:0] REG_OFS0 = 4'h2;
  localparam logic [3:0] REG_OFS1 = 4'h3;
  localparam logic [3:0] REG_GAIN0 = 4'h4;
  localparam logic [3:0] REG_GAIN1 = 4'h5;
  localparam logic [3:0] REG_TEST = 4'h6;
  localparam logic [3:0] REG_RESET = 4'h7;
  localparam logic [3:0] REG_DIAG = 4'h8;
  localparam int SOFT_RESET_POS = 0;
  localparam int SOFT_CONFIRM_POS = 1;
  localparam int RESET_SEEN_POS = 0;
  localparam logic [31:0] SOFT_RESET_WORD = 32'h00000003;
  localparam logic [2:0] RST_FORMAT = 3'h0;
  localparam logic [4:0] RST_AVG = 5'h00;
  localparam logic [4:0] AVG_MIN = 5'h01;
  localparam logic [4:0] AVG_MAX = 5'h10;
  localparam logic [23:0] RST_OFS = 24'h000000;
  localparam logic [15:0] RST_GAIN = 16'h8000;
  localparam int GAIN_SHIFT = 15;
  localparam logic [31:0] RST_TEST = 32'h5a5a0f0f;
  localparam logic [23:0] SAT_MAX = 24'h7fffff;
  localparam logic [23:0] SAT_MIN = 24'h800000;
  localparam logic [7:0] CM_MAX = 8'hff;
  localparam int FRAC_BITS = 6;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_MHZ = 100;
  localparam int RESET_PW_NS = 50;
  localparam int RESET_PW_CYC = (RESET_PW_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_US = 750;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int POWERUP_MS = 3;
  localparam int POWERUP_CYC = POWERUP_MS * 1000 * CLK_MHZ;
  // ***************************************************************
  // host apb map
  // ***************************************************************
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_STATUS = 8'h04;
  localparam logic [7:0] H_PERIOD = 8'h08;
  localparam logic [7:0] H_DEV_ADDR = 8'h0c;
  localparam logic [7:0] H_DEV_WDATA = 8'h10;
  localparam logic [7:0] H_DEV_CMD = 8'h14;
  localparam logic [7:0] H_DEV_RDATA = 8'h18;
  localparam logic [7:0] H_SAMPLE0 = 8'h1c;
  localparam logic [7:0] H_SAMPLE1 = 8'h20;
  localparam int CTRL_HW_RESET = 0;
  localparam int CTRL_SOFT_RESET = 1;
  localparam int CTRL_CONV_EN = 2;
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ = 1;
  localparam logic [15:0] RST_PERIOD = 16'h0031;
endpackage : sample_post_pkg
`default_nettype wire

// >>> src/sample_link_if.sv
// link between host controller and sample post-processing device
`default_nettype none
interface sample_link_if;
  logic hw_reset_n;
  logic convert_strobe;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic sample_valid;
  logic [31:0] ch0_word;
  logic [31:0] ch1_word;
  modport device (
    input hw_reset_n, convert_strobe, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, sample_valid, ch0_word, ch1_word
  );
  modport host (
    output hw_reset_n, convert_strobe, reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata, sample_valid, ch0_word, ch1_word
  );
endinterface : sample_link_if
`default_nettype wire

// >>> src/sample_post_device.sv
// dual channel offset, gain, common-mode, averaging and test-word output
`default_nettype none
module sample_post_device #(
  parameter int ACC_W = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  sample_link_if.device link,
  input wire logic [23:0] ch0_raw,
  input wire logic [23:0] ch1_raw,
  input wire logic [8:0] ch0_cm_level,
  input wire logic [8:0] ch1_cm_level,
  input wire logic ch0_raw_sat,
  input wire logic ch1_raw_sat
);
  import sample_post_pkg::*;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // offset, gain, saturate; msb of result flags saturation
  function automatic logic [24:0] scale(input logic [23:0] d,
                                        input logic [23:0] ofs,
                                        input logic [15:0] g);
    logic signed [24:0] s;
    logic signed [41:0] p;
    logic signed [26:0] q;
    s = $signed({d[23], d}) + $signed({ofs[23], ofs});
    p = s * $signed({1'b0, g});
    q = p[41:GAIN_SHIFT];
    if (q > $signed({3'b000, SAT_MAX})) begin
      scale = {1'b1, SAT_MAX};
    end else if (q < $signed({3'b111, SAT_MIN})) begin
      scale = {1'b1, SAT_MIN};
    end else begin
      scale = {1'b0, q[23:0]};
    end
  endfunction : scale

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  logic [2:0] format;
  logic [4:0] avg_exp;
  logic [23:0] ofs [2];
  logic [15:0] gain [2];
  logic [31:0] test_word;
  logic reset_seen;
  logic soft_hit;
  logic local_reset;

  assign soft_hit = link.reg_wr && link.reg_addr == REG_RESET &&
                    link.reg_wdata[SOFT_RESET_POS] &&
                    link.reg_wdata[SOFT_CONFIRM_POS];
  assign local_reset = !link.hw_reset_n || soft_hit;

  // configuration writes; every reset restores defaults
  // defaults on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      format <= RST_FORMAT;
      avg_exp <= RST_AVG;
      ofs[0] <= RST_OFS;
      ofs[1] <= RST_OFS;
      gain[0] <= RST_GAIN;
      gain[1] <= RST_GAIN;
      test_word <= RST_TEST;
    end else if (local_reset) begin
      format <= RST_FORMAT;
      avg_exp <= RST_AVG;
      ofs[0] <= RST_OFS;
      ofs[1] <= RST_OFS;
      gain[0] <= RST_GAIN;
      gain[1] <= RST_GAIN;
      test_word <= RST_TEST;
    end else if (link.reg_wr) begin
      case (link.reg_addr)
        REG_FORMAT: format <= link.reg_wdata[2:0];
        REG_AVG: avg_exp <= link.reg_wdata[4:0];
        REG_OFS0: ofs[0] <= link.reg_wdata[23:0];
        REG_OFS1: ofs[1] <= link.reg_wdata[23:0];
        REG_GAIN0: gain[0] <= link.reg_wdata[15:0];
        REG_GAIN1: gain[1] <= link.reg_wdata[15:0];
        REG_TEST: test_word <= link.reg_wdata;
        default: ;
      endcase
    end
  end

  // reset sets flag, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_seen <= 1'b1;
    end else if (local_reset) begin
      reset_seen <= 1'b1;
    end else if (link.reg_wr && link.reg_addr == REG_DIAG &&
                 link.reg_wdata[RESET_SEEN_POS]) begin
      reset_seen <= 1'b0;
    end
  end

  // register read data, one cycle after the read strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.reg_rdata <= 32'h00000000;
    end else if (link.reg_rd) begin
      case (link.reg_addr)
        REG_FORMAT: link.reg_rdata <= {29'h0, format};
        REG_AVG: link.reg_rdata <= {27'h0, avg_exp};
        REG_OFS0: link.reg_rdata <= {8'h00, ofs[0]};
        REG_OFS1: link.reg_rdata <= {8'h00, ofs[1]};
        REG_GAIN0: link.reg_rdata <= {16'h0000, gain[0]};
        REG_GAIN1: link.reg_rdata <= {16'h0000, gain[1]};
        REG_TEST: link.reg_rdata <= test_word;
        REG_DIAG: link.reg_rdata <= {31'h0, reset_seen};
        default: link.reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // ***************************************************************
  // block counter
  // ***************************************************************
  logic avg_on;
  logic [16:0] blk_cnt;
  logic blk_last;

  assign avg_on = format == FMT_AVG && avg_exp >= AVG_MIN &&
                  avg_exp <= AVG_MAX;
  assign blk_last = blk_cnt == 17'((18'h1 << avg_exp) - 18'h1);

  // strobes within the current block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_cnt <= 17'h0;
    end else if (local_reset || !avg_on) begin
      blk_cnt <= 17'h0;
    end else if (link.convert_strobe) begin
      blk_cnt <= blk_last ? 17'h0 : blk_cnt + 17'h1;
    end
  end

  // sample valid follows the strobe by one cycle
  // normal per-conversion timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.sample_valid <= 1'b0;
    end else begin
      link.sample_valid <= link.convert_strobe && !local_reset;
    end
  end

  // ***************************************************************
  // per-channel datapath
  // ***************************************************************
  logic [23:0] raw [2];
  logic [8:0] cm_level [2];
  logic raw_sat [2];
  logic [31:0] word [2];

  assign raw[0] = ch0_raw;
  assign raw[1] = ch1_raw;
  assign cm_level[0] = ch0_cm_level;
  assign cm_level[1] = ch1_cm_level;
  assign raw_sat[0] = ch0_raw_sat;
  assign raw_sat[1] = ch1_raw_sat;
  assign link.ch0_word = word[0];
  assign link.ch1_word = word[1];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [24:0] sc;
    logic [23:0] diff;
    logic sat;
    logic [7:0] cm;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] sum_now;
    logic signed [ACC_W+FRAC_BITS-1:0] shifted;
    logic orf;
    logic ovr_now;
    logic [31:0] fmt_word;

    assign sc = scale(raw[c], ofs[c], gain[c]);
    assign diff = sc[23:0];
    assign sat = sc[24] || raw_sat[c];
    assign cm = cm_level[c] > {1'b0, CM_MAX} ? CM_MAX : cm_level[c][7:0];
    assign sum_now = acc + ACC_W'($signed(diff));
    assign ovr_now = orf || sat;
    assign shifted = $signed({sum_now, {FRAC_BITS{1'b0}}}) >>> avg_exp;

    // non-averaged word, same format on both channels
    // format select
    always_comb begin
      case (format)
        FMT_CM16: fmt_word = {diff[23:8], cm, 8'h00};
        FMT_CM24: fmt_word = {diff, cm};
        FMT_TEST: fmt_word = test_word;
        default: fmt_word = {diff, 8'h00};
      endcase
    end

    // accumulator, overrange and output word
    // block sum and done flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc <= '0;
        orf <= 1'b0;
        word[c] <= 32'h00000000;
      end else if (local_reset) begin
        acc <= '0;
        orf <= 1'b0;
        word[c] <= 32'h00000000;
      end else if (link.convert_strobe) begin
        if (avg_on && blk_last) begin
          acc <= '0;
          orf <= 1'b0;
          word[c] <= {1'b1, ovr_now, shifted[29:0]};
        end else if (avg_on) begin
          acc <= sum_now;
          orf <= ovr_now;
          word[c] <= {1'b0, word[c][30:0]};
        end else begin
          acc <= '0;
          orf <= 1'b0;
          word[c] <= fmt_word;
        end
      end
    end
  end
endmodule : sample_post_device
`default_nettype wire

// >>> src/sample_post_host.sv
// host controller: apb slave, reset sequencing, strobes, register access
`default_nettype none
module sample_post_host #(
  parameter int POWERUP_CYCLES = sample_post_pkg::POWERUP_CYC,
  parameter int SETTLE_CYCLES = sample_post_pkg::SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sample_link_if.host link
);
  import sample_post_pkg::*;

  typedef enum logic [1:0] {S_POWERUP, S_PULSE, S_SETTLE, S_READY} state_e;
  state_e state;
  logic [18:0] wait_cnt;
  logic wr_acc;
  logic rd_setup;
  logic ready;
  logic hw_req;
  logic soft_req;
  logic cmd_req;
  logic conv_en;
  logic [15:0] period;
  logic [15:0] conv_cnt;
  logic [3:0] dev_addr;
  logic [31:0] dev_wdata;
  logic [31:0] dev_rdata;
  logic [31:0] sample [2];
  logic [15:0] sample_count;
  logic rd_pend;

  // ***************************************************************
  // apb decode
  // ***************************************************************
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign ready = state == S_READY;
  assign hw_req = wr_acc && paddr == H_CTRL && pwdata[CTRL_HW_RESET];
  assign soft_req = wr_acc && paddr == H_CTRL && pwdata[CTRL_SOFT_RESET];
  assign cmd_req = wr_acc && paddr == H_DEV_CMD;
  // pin low only during pulse state
  assign link.hw_reset_n = state != S_PULSE;

  // read data latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        H_CTRL: prdata <= {29'h0, conv_en, 2'b00};
        H_STATUS: prdata <= {sample_count, 15'h0, ready};
        H_PERIOD: prdata <= {16'h0000, period};
        H_DEV_ADDR: prdata <= {28'h0, dev_addr};
        H_DEV_WDATA: prdata <= dev_wdata;
        H_DEV_RDATA: prdata <= dev_rdata;
        H_SAMPLE0: prdata <= sample[0];
        H_SAMPLE1: prdata <= sample[1];
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_en <= 1'b0;
      period <= RST_PERIOD;
      dev_addr <= 4'h0;
      dev_wdata <= 32'h00000000;
    end else if (wr_acc) begin
      case (paddr)
        H_CTRL: conv_en <= pwdata[CTRL_CONV_EN];
        H_PERIOD: period <= pwdata[15:0];
        H_DEV_ADDR: dev_addr <= pwdata[3:0];
        H_DEV_WDATA: dev_wdata <= pwdata;
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // reset sequencer
  // ***************************************************************
  // wait after power-up, then reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_POWERUP;
      wait_cnt <= 19'h0;
    end else begin
      case (state)
        S_POWERUP: begin
          if (wait_cnt == 19'(POWERUP_CYCLES - 1)) begin
            state <= S_PULSE;
            wait_cnt <= 19'h0;
          end else begin
            wait_cnt <= wait_cnt + 19'h1;
          end
        end
        S_PULSE: begin
          if (wait_cnt == 19'(RESET_PW_CYC - 1)) begin
            state <= S_SETTLE;
            wait_cnt <= 19'h0;
          end else begin
            wait_cnt <= wait_cnt + 19'h1;
          end
        end
        S_SETTLE: begin
          if (wait_cnt == 19'(SETTLE_CYCLES - 1)) begin
            state <= S_READY;
            wait_cnt <= 19'h0;
          end else begin
            wait_cnt <= wait_cnt + 19'h1;
          end
        end
        S_READY: begin
          wait_cnt <= 19'h0;
          if (hw_req) begin
            state <= S_PULSE;
          end else if (soft_req) begin
            state <= S_SETTLE;
          end
        end
        default: state <= S_POWERUP;
      endcase
    end
  end

  // ***************************************************************
  // device register access
  // ***************************************************************
  // both bits in one write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      link.reg_addr <= 4'h0;
      link.reg_wdata <= 32'h00000000;
    end else if (ready && !hw_req && soft_req) begin
      link.reg_wr <= 1'b1;
      link.reg_rd <= 1'b0;
      link.reg_addr <= REG_RESET;
      link.reg_wdata <= SOFT_RESET_WORD;
    end else if (ready && cmd_req) begin
      link.reg_wr <= pwdata[CMD_WRITE];
      link.reg_rd <= pwdata[CMD_READ] && !pwdata[CMD_WRITE];
      link.reg_addr <= dev_addr;
      link.reg_wdata <= dev_wdata;
    end else begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
    end
  end

  // capture device read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pend <= 1'b0;
      dev_rdata <= 32'h00000000;
    end else begin
      rd_pend <= link.reg_rd;
      if (rd_pend) begin
        dev_rdata <= link.reg_rdata;
      end
    end
  end

  // ***************************************************************
  // conversion strobes and sample capture
  // ***************************************************************
  // strobes only when settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt <= 16'h0;
      link.convert_strobe <= 1'b0;
    end else if (ready && conv_en) begin
      link.convert_strobe <= conv_cnt == period;
      conv_cnt <= conv_cnt == period ? 16'h0 : conv_cnt + 16'h1;
    end else begin
      conv_cnt <= 16'h0;
      link.convert_strobe <= 1'b0;
    end
  end

  // latest words from both channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample[0] <= 32'h00000000;
      sample[1] <= 32'h00000000;
      sample_count <= 16'h0;
    end else if (link.sample_valid) begin
      sample[0] <= link.ch0_word;
      sample[1] <= link.ch1_word;
      sample_count <= sample_count + 16'h1;
    end
  end
endmodule : sample_post_host
`default_nettype wire

// >>> bench/sample_link_assertions.sv
// concurrent checks on the host-device link
`default_nettype none
module sample_link_assertions
  import sample_post_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hw_reset_n,
  input wire logic convert_strobe,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [31:0] ch0_word,
  input wire logic [31:0] ch1_word
);
  logic soft_wr;
  logic [2:0] fmt;
  logic [31:0] tword;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // soft reset write, both bits
  assign soft_wr = reg_wr && reg_addr == REG_RESET && reg_wdata[1:0] == 2'h3;
  // shadows of output format and test word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt <= RST_FORMAT;
      tword <= RST_TEST;
    end else if (!hw_reset_n || soft_wr) begin
      fmt <= RST_FORMAT;
      tword <= RST_TEST;
    end else if (reg_wr) begin
      if (reg_addr == REG_FORMAT) fmt <= reg_wdata[2:0];
      if (reg_addr == REG_TEST) tword <= reg_wdata;
    end
  end
  valid_after_strobe_a: assert property (
    convert_strobe && hw_reset_n && !soft_wr |=> sample_valid)
    else $error("sample missing after strobe");
  valid_needs_strobe_a: assert property (
    sample_valid |-> $past(convert_strobe))
    else $error("sample without strobe");
  words_hold_a: assert property (
    !sample_valid && $past(hw_reset_n) && !$past(soft_wr)
    |-> $stable(ch0_word) && $stable(ch1_word))
    else $error("words moved");
  test_both_a: assert property (
    sample_valid && fmt == FMT_TEST && $stable(fmt) && $stable(tword)
    |-> ch0_word == tword && ch1_word == tword)
    else $error("test word wrong");
  cm16_low_a: assert property (
    sample_valid && fmt == FMT_CM16 && $stable(fmt)
    |-> ch0_word[7:0] == 8'h00 && ch1_word[7:0] == 8'h00)
    else $error("cm16 low byte set");
  diff_low_a: assert property (
    sample_valid && fmt == FMT_DIFF24 && $stable(fmt)
    |-> ch0_word[7:0] == 8'h00 && ch1_word[7:0] == 8'h00)
    else $error("plain low byte set");
  reset_pulse_a: assert property (
    $fell(hw_reset_n) |-> !hw_reset_n [*5])
    else $error("reset pulse too short");
  settle_wait_a: assert property (
    $rose(hw_reset_n) || soft_wr
    |=> (!convert_strobe && !reg_wr && !reg_rd) [*8])
    else $error("traffic too soon");
  rdata_hold_a: assert property (
    !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
endmodule : sample_link_assertions
`default_nettype wire

// >>> bench/tb_dual_adc_sample_postprocess.sv
// self-checking bench for the host and device pair
`default_nettype none
module tb_dual_adc_sample_postprocess import sample_post_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, w0, w1, tw = RST_TEST;
  logic pready, pslverr;
  logic [23:0] raw0 = 24'h0, raw1 = 24'h0, o0, o1;
  logic [8:0] cm0 = 9'h0, cm1 = 9'h0;
  logic [15:0] g0, g1;
  int bad_count = 0, checks_done = 0, seed = 73;
  sample_link_if link ();
  always #5 pclk = ~pclk;
  sample_post_host #(.POWERUP_CYCLES(20), .SETTLE_CYCLES(10))
    sample_post_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  sample_post_device sample_post_device_inst (.pclk(pclk),
    .presetn(presetn), .link(link), .ch0_raw(raw0), .ch1_raw(raw1),
    .ch0_cm_level(cm0), .ch1_cm_level(cm1), .ch0_raw_sat(1'b0),
    .ch1_raw_sat(1'b0));
  sample_link_assertions sample_link_assertions_inst (.pclk(pclk),
    .presetn(presetn), .hw_reset_n(link.hw_reset_n),
    .convert_strobe(link.convert_strobe), .reg_wr(link.reg_wr),
    .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .sample_valid(link.sample_valid), .ch0_word(link.ch0_word),
    .ch1_word(link.ch1_word));
  // compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // device register access through the host
  task automatic dev_wr(input logic [3:0] i, input logic [31:0] d);
    apb(1'b1, H_DEV_ADDR, {28'h0, i}, rd);
    apb(1'b1, H_DEV_WDATA, d, rd);
    apb(1'b1, H_DEV_CMD, 32'h1 << CMD_WRITE, rd);
  endtask : dev_wr
  task automatic dev_rd(input logic [3:0] i, output logic [31:0] d);
    apb(1'b1, H_DEV_ADDR, {28'h0, i}, d);
    apb(1'b1, H_DEV_CMD, 32'h1 << CMD_READ, d);
    repeat (3) @(posedge pclk);
    apb(1'b0, H_DEV_RDATA, 32'h0, d);
  endtask : dev_rd
  // poll host status until ready
  task automatic wait_ready();
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, H_STATUS, 32'h0, rd);
      if (rd[0] === 1'b1) break;
    end
    check("ready", {31'h0, rd[0]}, 32'h1);
  endtask : wait_ready
  // next sample pulse, bounded
  task automatic get_sample(output logic [31:0] a, output logic [31:0] b);
    for (int i = 0; i < 400; i++) begin
      @(negedge pclk);
      if (link.sample_valid === 1'b1) break;
    end
    check("sample_valid", {31'h0, link.sample_valid}, 32'h1);
    a = link.ch0_word;
    b = link.ch1_word;
  endtask : get_sample
  // reference offset, gain and clamp
  function automatic logic [23:0] proc(input logic [23:0] r,
    input logic [23:0] o, input logic [15:0] g);
    longint v;
    v = (longint'($signed(r)) + longint'($signed(o))) * longint'(g);
    v = v >>> GAIN_SHIFT;
    if (v > 64'sd8388607) return SAT_MAX;
    if (v < -64'sd8388608) return SAT_MIN;
    return v[23:0];
  endfunction : proc
  // reference output word
  function automatic logic [31:0] fword(input logic [2:0] f,
    input logic [23:0] d, input logic [8:0] cm);
    logic [7:0] c;
    c = (cm > 9'h0ff) ? CM_MAX : cm[7:0];
    case (f)
      FMT_CM16: return {d[23:8], c, 8'h00};
      FMT_CM24: return {d, c};
      FMT_TEST: return tw;
      default: return {d, 8'h00};
    endcase
  endfunction : fword
  initial begin
    #300000;
    bad_count++;
    end_sim();
  end
  initial begin
    logic [31:0] dflt [10];
    int n;
    dflt = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h8000, 32'h8000, RST_TEST,
             32'h0, 32'h1, 32'h0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_ready();
    for (int i = 0; i < 10; i++) begin
      dev_rd(4'(i), rd);
      check("device default", rd, dflt[i]);
    end
    dev_wr(REG_DIAG, 32'h1);
    dev_rd(REG_DIAG, rd);
    check("reset seen clear", rd, 32'h0);
    apb(1'b0, 8'h3c, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    $display("test defaults done");
    o0 = 24'($random(seed));
    o1 = 24'($random(seed));
    g0 = 16'($random(seed));
    g1 = 16'($random(seed));
    dev_wr(REG_OFS0, {8'h00, o0});
    dev_wr(REG_OFS1, {8'h00, o1});
    dev_wr(REG_GAIN0, {16'h0, g0});
    dev_wr(REG_GAIN1, {16'h0, g1});
    apb(1'b1, H_PERIOD, 32'h7, rd);
    apb(1'b1, H_CTRL, 32'h1 << CTRL_CONV_EN, rd);
    for (int f = 0; f < 8; f++) begin
      dev_wr(REG_FORMAT, 32'(f));
      get_sample(w0, w1);
      for (int k = 0; k < 4; k++) begin
        @(posedge pclk);
        raw0 <= 24'($random(seed));
        raw1 <= 24'($random(seed));
        cm0 <= 9'($random(seed));
        cm1 <= 9'($random(seed));
        get_sample(w0, w1);
        check("ch0", w0, fword(3'(f), proc(raw0, o0, g0), cm0));
        check("ch1", w1, fword(3'(f), proc(raw1, o1, g1), cm1));
      end
    end
    $display("test formats done");
    tw = $random(seed);
    dev_wr(REG_TEST, tw);
    dev_wr(REG_FORMAT, 32'(FMT_TEST));
    get_sample(w0, w1);
    get_sample(w0, w1);
    check("test ch0", w0, tw);
    check("test ch1", w1, tw);
    @(posedge pclk);
    raw0 <= 24'($random(seed));
    raw1 <= SAT_MAX;
    dev_wr(REG_OFS0, 32'h0);
    dev_wr(REG_OFS1, 32'h0);
    dev_wr(REG_GAIN0, 32'h8000);
    dev_wr(REG_GAIN1, 32'hffff);
    dev_wr(REG_AVG, 32'h2);
    dev_wr(REG_FORMAT, 32'(FMT_AVG));
    get_sample(w0, w1);
    n = 0;
    for (int k = 0; k < 8; k++) begin
      get_sample(w0, w1);
      if (w0[31] === 1'b1) begin
        n++;
        check("avg ch0", w0, {2'h2, raw0, 6'h00});
        check("avg ch1", w1, {2'h3, SAT_MAX, 6'h00});
      end
    end
    check("blocks", 32'(n), 32'h2);
    $display("test averaging done");
    dev_wr(REG_RESET, 32'h1 << SOFT_RESET_POS);
    dev_rd(REG_FORMAT, rd);
    check("lone reset bit", rd, 32'(FMT_AVG));
    apb(1'b1, H_CTRL, 32'h1 << CTRL_SOFT_RESET, rd);
    wait_ready();
    dev_rd(REG_FORMAT, rd);
    check("soft format", rd, 32'(RST_FORMAT));
    dev_rd(REG_DIAG, rd);
    check("soft seen", rd, 32'h1);
    dev_wr(REG_GAIN1, 32'h1234);
    dev_wr(REG_DIAG, 32'h1);
    apb(1'b1, H_CTRL, 32'h1 << CTRL_HW_RESET, rd);
    wait_ready();
    dev_rd(REG_DIAG, rd);
    check("hw seen", rd, 32'h1);
    dev_rd(REG_GAIN1, rd);
    check("hw gain", rd, 32'h8000);
    $display("test resets done");
    end_sim();
  end
endmodule : tb_dual_adc_sample_postprocess
`default_nettype wire
